//--- inc/sfp_pkg.sv
// Constants and types shared by the serial flash pin interface
package sfp_pkg;

  // ****************************************
  // Opcodes handled at the pin level
  // ****************************************
  localparam logic [7:0] SFP_OP_ENTER_4W = 8'h38;
  localparam logic [7:0] SFP_OP_EXIT_4W  = 8'h FF;

  // ****************************************
  // Lane width codes and bit counts
  // ****************************************
  localparam logic [1:0] SFP_LANE_1    = 2'h0;
  localparam logic [1:0] SFP_LANE_2    = 2'h1;
  localparam logic [1:0] SFP_LANE_4    = 2'h2;
  localparam logic [3:0] SFP_BYTE_BITS = 4'h8;
  localparam logic [3:0] SFP_STEP_1    = 4'h1;
  localparam logic [3:0] SFP_STEP_2    = 4'h2;
  localparam logic [3:0] SFP_STEP_4    = 4'h4;

  // ****************************************
  // Pin sample vector layout
  // ****************************************
  localparam int SFP_PIN_CS    = 5;
  localparam int SFP_PIN_SCK   = 4;
  localparam int SFP_PIN_IO3   = 3;
  localparam int SFP_PIN_WIDTH = 6;

  // Frame phase
  typedef enum logic [1:0] {
    SFP_PH_IDLE   = 2'b00,
    SFP_PH_OPCODE = 2'b01,
    SFP_PH_DATA   = 2'b10
  } sfp_phase_t;

endpackage : sfp_pkg

//--- core/sfp_pin_interface.sv
// Serial flash pin front end: clock sampling, lane muxing, pause and reset pin roles
// Summary of operation
// - Quad enable makes pin four data line 3
// - Role bit picks pause or hardware reset
// - Pause freezes sequence without losing bits
// - Paused and selected: serial output released
// - Pause release resumes where it stopped
// - Idle clock low or high both accepted
// - Capture on rising, drive from falling
// - Dual transfers use lines 0 and 1
// - Quad or four-wire uses lines 0 to 3
// - Opcode 38h enters, FFh leaves four-wire
// - Opcode takes eight clocks or two
// - rst_n or softReset returns to single-line mode; the reset pin role is off in four-wire
module sfp_pin_interface
  import sfp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       chipSelectN,
  input  wire logic       serialClk,
  input  wire logic [3:0] dataLineIn,
  output logic      [3:0] dataLineOut,
  output logic      [3:0] dataLineOe,
  input  wire logic       quadEnableBit,
  input  wire logic       pinRoleSelect,
  input  wire logic       softReset,
  input  wire logic [1:0] busLanes,
  input  wire logic       txDir,
  input  wire logic [7:0] txByte,
  output logic            txTake,
  output logic      [7:0] opcodeByte,
  output logic            opcodeValid,
  output logic      [7:0] rxByte,
  output logic            rxValid,
  output logic            fourWireCommandMode,
  output logic            pausedState,
  output logic            hwResetN
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [3:0] stepOf(input logic [1:0] lane);
    if (lane == SFP_LANE_4) begin
      return SFP_STEP_4;
    end else if (lane == SFP_LANE_2) begin
      return SFP_STEP_2;
    end
    return SFP_STEP_1;
  endfunction : stepOf

  // MSB first; single lane drives line 1, dual drives 1:0, quad 3:0
  function automatic logic [3:0] laneBits(input logic [7:0] b, input logic [1:0] lane);
    if (lane == SFP_LANE_4) begin
      return b[7:4];
    end else if (lane == SFP_LANE_2) begin
      return {2'h0, b[7:6]};
    end
    return {2'h0, b[7], 1'b0};
  endfunction : laneBits

  function automatic logic [3:0] laneMask(input logic [1:0] lane);
    if (lane == SFP_LANE_4) begin
      return 4'hF;
    end else if (lane == SFP_LANE_2) begin
      return 4'h3;
    end
    return 4'h2;
  endfunction : laneMask

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SFP_PIN_WIDTH-1:0] pinMeta_r;
  logic [SFP_PIN_WIDTH-1:0] pinSync_r;
  logic                     sckPrev_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinMeta_r <= 6'h3F;
      pinSync_r <= 6'h3F;
      // Same level as the preloaded sync stage: no edge out of reset
      sckPrev_r <= 1'b1;
    end else begin
      pinMeta_r <= {chipSelectN, serialClk, dataLineIn};
      pinSync_r <= pinMeta_r;
      sckPrev_r <= pinSync_r[SFP_PIN_SCK];
    end
  end

  // ****************************************
  // Pin roles and edges
  // ****************************************
  sfp_phase_t phase_r;
  logic [3:0] bitCnt_r;
  logic [7:0] rxShift_r;
  logic [3:0] outCnt_r;
  logic [7:0] txShift_r;
  logic       csHigh;
  logic       pauseRole;
  logic       resetRole;
  logic       paused;
  logic       hwResetReq;
  logic       sckRise;
  logic       sckFall;
  logic [1:0] curLane;
  logic [3:0] step;
  logic [7:0] inNxt;
  logic [3:0] inLanes;

  assign csHigh     = pinSync_r[SFP_PIN_CS];
  assign pauseRole  = !quadEnableBit && !pinRoleSelect && !fourWireCommandMode;
  assign resetRole  = !quadEnableBit && pinRoleSelect && !fourWireCommandMode;
  assign paused     = pauseRole && !pinSync_r[SFP_PIN_IO3] && !csHigh;
  assign hwResetReq = resetRole && !pinSync_r[SFP_PIN_IO3];
  // Only edges seen while selected and not paused count; idle level is irrelevant
  assign sckRise = pinSync_r[SFP_PIN_SCK] && !sckPrev_r && !csHigh && !paused;
  assign sckFall = !pinSync_r[SFP_PIN_SCK] && sckPrev_r && !csHigh && !paused;

  // Four-wire mode forces quad on every phase; opcode is single-line otherwise
  assign curLane = fourWireCommandMode ? SFP_LANE_4 :
                   (phase_r == SFP_PH_DATA ? busLanes : SFP_LANE_1);
  assign step    = stepOf(curLane);
  assign inLanes = pinSync_r[3:0];

  always_comb begin
    if (curLane == SFP_LANE_4) begin
      inNxt = {rxShift_r[3:0], inLanes};
    end else if (curLane == SFP_LANE_2) begin
      inNxt = {rxShift_r[5:0], inLanes[1:0]};
    end else begin
      inNxt = {rxShift_r[6:0], inLanes[0]};
    end
  end

  // ****************************************
  // Capture path
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n || hwResetReq || csHigh) begin
      phase_r     <= SFP_PH_IDLE;
      bitCnt_r    <= 4'h0;
      rxShift_r   <= 8'h00;
      opcodeValid <= 1'b0;
      rxValid     <= 1'b0;
      if (!rst_n) begin
        opcodeByte <= 8'h00;
        rxByte     <= 8'h00;
      end
    end else begin
      opcodeValid <= 1'b0;
      rxValid     <= 1'b0;
      case (phase_r)
        SFP_PH_IDLE: begin
          phase_r  <= SFP_PH_OPCODE;
          bitCnt_r <= 4'h0;
        end
        default: begin
          // Frozen while paused: bit count and partial byte are kept
          if (sckRise) begin
            rxShift_r <= inNxt;
            if (bitCnt_r + step == SFP_BYTE_BITS) begin
              bitCnt_r <= 4'h0;
              if (phase_r == SFP_PH_OPCODE) begin
                opcodeByte  <= inNxt;
                opcodeValid <= 1'b1;
                phase_r     <= SFP_PH_DATA;
              end else begin
                rxByte  <= inNxt;
                rxValid <= 1'b1;
              end
            end else begin
              bitCnt_r <= bitCnt_r + step;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Drive path
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dataLineOut <= 4'h0;
      txShift_r   <= 8'h00;
      outCnt_r    <= 4'h0;
      txTake      <= 1'b0;
    end else begin
      txTake <= 1'b0;
      if (csHigh || hwResetReq) begin
        outCnt_r <= 4'h0;
      end else if (sckFall && phase_r == SFP_PH_DATA && txDir) begin
        if (outCnt_r == 4'h0) begin
          dataLineOut <= laneBits(txByte, curLane);
          txShift_r   <= txByte << step;
          outCnt_r    <= SFP_BYTE_BITS - step;
          txTake      <= 1'b1;
        end else begin
          dataLineOut <= laneBits(txShift_r, curLane);
          txShift_r   <= txShift_r << step;
          outCnt_r    <= outCnt_r - step;
        end
      end
    end
  end

  // Enables released on deselect, pause or pin reset; no bus fight on shared lines
  always_ff @(posedge clk) begin
    if (!rst_n || csHigh || paused || hwResetReq) begin
      dataLineOe <= 4'h0;
    end else if (phase_r == SFP_PH_DATA && txDir) begin
      dataLineOe <= laneMask(curLane);
    end else begin
      dataLineOe <= 4'h0;
    end
  end

  // ****************************************
  // Mode and pin role state
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n || softReset || hwResetReq) begin
      fourWireCommandMode <= 1'b0;
    end else if (csHigh && phase_r == SFP_PH_DATA) begin
      // Switch only once the command frame closes
      if (opcodeByte == SFP_OP_ENTER_4W) begin
        fourWireCommandMode <= 1'b1;
      end else if (opcodeByte == SFP_OP_EXIT_4W) begin
        fourWireCommandMode <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pausedState <= 1'b0;
      hwResetN    <= 1'b1;
    end else begin
      pausedState <= paused;
      hwResetN    <= !hwResetReq;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  chk_quad_no_pause: assert property (@(posedge clk) disable iff (!rst_n)
    $past(quadEnableBit) && quadEnableBit |-> !pausedState && hwResetN)
    else $error("pause or reset role active with quad enable set");

  chk_reset_role: assert property (@(posedge clk) disable iff (!rst_n)
    hwResetReq |=> !hwResetN && !fourWireCommandMode)
    else $error("reset role low did not reset");

  chk_pause_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    paused && !csHigh && phase_r != SFP_PH_IDLE |=> $stable(bitCnt_r) && $stable(rxShift_r))
    else $error("sequence moved while paused");

  chk_pause_hiz: assert property (@(posedge clk) disable iff (!rst_n)
    pausedState |-> dataLineOe == 4'h0)
    else $error("line driven while paused");

  chk_resume_keep: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(pausedState) && !csHigh |-> bitCnt_r == $past(bitCnt_r, 2))
    else $error("bit position lost over pause");

  chk_fall_drive: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(dataLineOut) |-> $past(sckFall))
    else $error("output changed without falling edge");

  chk_rise_capture: assert property (@(posedge clk) disable iff (!rst_n)
    sckRise && phase_r != SFP_PH_IDLE |=> bitCnt_r != $past(bitCnt_r) || $past(bitCnt_r + step) == 4'h8)
    else $error("rising edge not captured");

  chk_lane_width: assert property (@(posedge clk) disable iff (!rst_n)
    dataLineOe[3] || dataLineOe[0] |-> $past(curLane) != SFP_LANE_1)
    else $error("extra lane driven in single mode");

  chk_four_wire_op: assert property (@(posedge clk) disable iff (!rst_n)
    csHigh && phase_r == SFP_PH_DATA && opcodeByte == SFP_OP_ENTER_4W
      && !softReset && !hwResetReq |=> fourWireCommandMode)
    else $error("four-wire mode not entered");

  chk_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
    softReset |=> !fourWireCommandMode)
    else $error("software reset kept four-wire mode");

  chk_deselect_idle: assert property (@(posedge clk) disable iff (!rst_n)
    csHigh |=> dataLineOe == 4'h0 && !rxValid && !opcodeValid)
    else $error("activity while deselected");

  cov_enter_four: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(fourWireCommandMode));
  cov_pause: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(pausedState) && !csHigh);
  cov_quad_read: cover property (@(posedge clk) disable iff (!rst_n)
    txTake && curLane == SFP_LANE_4);
  cov_rx_byte: cover property (@(posedge clk) disable iff (!rst_n) rxValid);

endmodule : sfp_pin_interface

//--- bench/sfp_master_model.sv
// Behavioural serial bus master that drives the flash pins
module sfp_master_model (
  output logic             csN,
  output logic             sck,
  output logic       [3:0] drv,
  input  wire  logic [3:0] pin,
  input  wire  logic [3:0] oe,
  output logic       [3:0] oeSeen,
  output logic             holdOn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic idleHi;

  initial begin
    csN    = 1'b1;
    sck    = 1'b0;
    drv    = 4'hF;
    oeSeen = 4'h0;
    holdOn = 1'b0;
    idleHi = 1'b0;
  end

  // ****************************************
  // Frame framing
  // ****************************************
  // Odd offsets keep pin changes clear of the sampling clock edge
  task automatic frame_start(input logic mode3);
    idleHi = mode3;
    sck    = mode3;
    drv    = 4'hF;
    #105 csN = 1'b0;
    #100;
  endtask : frame_start

  task automatic frame_end();
    #40 sck = idleHi;
    #80 csN = 1'b1;
    drv[2:0] = ~drv[2:0];
    #200;
  endtask : frame_end

  task automatic set_line3(input logic v);
    #5 drv[3] = v;
  endtask : set_line3

  task automatic idle_clocks();
    #5;
    repeat (8) #80 sck = ~sck;
  endtask : idle_clocks

  // ****************************************
  // One byte, MSB first, w lanes per clock
  // ****************************************
  task automatic shift_byte(input int w, input logic [7:0] tx, input logic rd,
                            input int holdAt, output logic [7:0] rx);
    logic [7:0] sh;
    sh = tx;
    rx = 8'h00;
    for (int s = 0; s < 8 / w; s++) begin
      sck = 1'b0;
      if (s == holdAt) begin
        // Pause after the fall is synchronised, so that fall still shifts a bit
        #40 drv[3] = 1'b0;
        holdOn = 1'b1;
        // Clock keeps running while paused
        repeat (2) begin
          #80 sck = 1'b1;
          #80 sck = 1'b0;
        end
        // Release with the clock settled low: no false fall on resume
        #40 drv[3] = 1'b1;
        holdOn = 1'b0;
        #80;
      end
      // Released lines get a changing pattern, never the old level
      if (w == 4) drv = rd ? ~drv : sh[7:4];
      else if (w == 2) drv = {2'b11, rd ? ~drv[1:0] : sh[7:6]};
      else drv = {2'b11, ~drv[1], rd ? ~drv[0] : sh[7]};
      sh = sh << w;
      #80 sck = 1'b1;
      // Late in the high phase: margin against the device's sync delay
      #70 oeSeen = oe;
      if (w == 4) rx = {rx[3:0], pin};
      else if (w == 2) rx = {rx[5:0], pin[1:0]};
      else rx = {rx[6:0], pin[1]};
      #10;
    end
  endtask : shift_byte
endmodule : sfp_master_model

//--- bench/tb.sv
// Self-checking bench of the serial flash pin front end
module tb
  import sfp_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, rst_n, qe, role, softReset, txDir, csN, sck, holdOn;
  logic       txTake, opcodeValid, rxValid, fourW, paused, hwResetN;
  logic [1:0] busLanes, ln;
  logic [3:0] drv, pinIn, out, oe, oeSeen;
  logic [7:0] txByte, opcodeByte, rxByte, gotOp, gotRx, op, d;
  int         n_fail, samples_checked, cyc, nOp, n0, seed, nTake;

  always #10 clk = ~clk;
  assign pinIn = (oe & out) | (~oe & drv);

  sfp_pin_interface sfp_pin_interface_inst (
    .clk(clk), .rst_n(rst_n), .chipSelectN(csN), .serialClk(sck), .dataLineIn(pinIn),
    .dataLineOut(out), .dataLineOe(oe), .quadEnableBit(qe), .pinRoleSelect(role),
    .softReset(softReset), .busLanes(busLanes), .txDir(txDir), .txByte(txByte),
    .txTake(txTake), .opcodeByte(opcodeByte), .opcodeValid(opcodeValid), .rxByte(rxByte),
    .rxValid(rxValid), .fourWireCommandMode(fourW), .pausedState(paused), .hwResetN(hwResetN));

  sfp_master_model sfp_master_model_inst (
    .csN(csN), .sck(sck), .drv(drv), .pin(pinIn), .oe(oe), .oeSeen(oeSeen), .holdOn(holdOn));

  // ****************************************
  // Capture, timeout and checking
  // ****************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (opcodeValid === 1'b1) begin
      gotOp <= opcodeByte;
      nOp   <= nOp + 1;
    end
    if (rxValid === 1'b1) gotRx <= rxByte;
    if (txTake === 1'b1) nTake <= nTake + 1;
    if (cyc == 20000) begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run

  function automatic logic [3:0] exp_oe(input logic [1:0] lanes);
    return (lanes == SFP_LANE_4) ? 4'hF : (lanes == SFP_LANE_2) ? 4'h3 : 4'h2;
  endfunction : exp_oe

  function automatic int width_of(input logic [1:0] lanes);
    return (lanes == SFP_LANE_4) ? 4 : (lanes == SFP_LANE_2) ? 2 : 1;
  endfunction : width_of

  task automatic frame(input logic m3, input logic [7:0] o, input int opW, input logic [1:0] lanes,
                       input logic rd, input logic [7:0] dat, input logic hasData, input int holdAt);
    logic [7:0] r;
    int         t0;
    @(posedge clk);
    t0 = nTake;
    busLanes <= lanes;
    txDir    <= rd;
    txByte   <= dat;
    qe       <= (lanes == SFP_LANE_4);
    sfp_master_model_inst.frame_start(m3);
    sfp_master_model_inst.shift_byte(opW, o, 1'b0, -1, r);
    if (hasData) sfp_master_model_inst.shift_byte(width_of(lanes), dat, rd, holdAt, r);
    sfp_master_model_inst.frame_end();
    check(gotOp, o);
    if (hasData && rd) begin
      check(r, dat);
      check(8'(oeSeen), 8'(exp_oe(lanes)));
      // Mode 0 ends on one more fall, which starts loading the next byte
      check(8'(nTake - t0), m3 ? 8'h01 : 8'h02);
    end else if (hasData) check(gotRx, dat);
  endtask : frame

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 0; rst_n = 0; qe = 0; role = 0; softReset = 0; busLanes = SFP_LANE_1;
    txDir = 0; txByte = 8'h00; gotOp = 8'h00; gotRx = 8'h00;
    n_fail = 0; samples_checked = 0; cyc = 0; nOp = 0; seed = 11976; nTake = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(negedge clk);
    check(fourW, 1'b0);
    for (int i = 0; i < 6; i++) begin
      op = $random(seed);
      d  = $random(seed);
      if (op == SFP_OP_ENTER_4W || op == SFP_OP_EXIT_4W) op = 8'h5A;
      // d later serves as an opcode too; a mode opcode would switch modes
      if (d == SFP_OP_ENTER_4W || d == SFP_OP_EXIT_4W) d = 8'hA5;
      ln = 2'(i % 3);
      frame(i > 2, op, 1, ln, i[0], d, 1'b1, -1);
    end
    // Pause mid-byte during a read
    fork
      frame(1'b0, op, 1, SFP_LANE_1, 1'b1, ~d, 1'b1, 3);
      begin
        wait (holdOn === 1'b1);
        repeat (10) @(negedge clk);
        check(paused, 1'b1);
        check(8'(oe), 8'h00);
      end
    join
    frame(1'b0, SFP_OP_ENTER_4W, 1, SFP_LANE_1, 1'b0, 8'h00, 1'b0, -1);
    check(fourW, 1'b1);
    frame(1'b1, d, 4, SFP_LANE_4, 1'b1, op, 1'b1, -1);
    frame(1'b0, SFP_OP_EXIT_4W, 4, SFP_LANE_1, 1'b0, 8'h00, 1'b0, -1);
    check(fourW, 1'b0);
    frame(1'b0, SFP_OP_ENTER_4W, 1, SFP_LANE_1, 1'b0, 8'h00, 1'b0, -1);
    @(posedge clk) softReset <= 1'b1;
    @(posedge clk) softReset <= 1'b0;
    repeat (2) @(negedge clk);
    check(fourW, 1'b0);
    // Pin roles
    @(posedge clk) role <= 1'b1;
    sfp_master_model_inst.set_line3(1'b0);
    repeat (6) @(negedge clk);
    check(hwResetN, 1'b0);
    sfp_master_model_inst.set_line3(1'b1);
    repeat (6) @(negedge clk);
    check(hwResetN, 1'b1);
    @(posedge clk) begin
      role <= 1'b0;
      qe   <= 1'b1;
    end
    sfp_master_model_inst.frame_start(1'b0);
    sfp_master_model_inst.set_line3(1'b0);
    repeat (6) @(negedge clk);
    check(paused, 1'b0);
    check(hwResetN, 1'b1);
    sfp_master_model_inst.set_line3(1'b1);
    sfp_master_model_inst.frame_end();
    // Clock activity while deselected
    n0 = nOp;
    sfp_master_model_inst.idle_clocks();
    check(8'(nOp - n0), 8'h00);
    check(8'(oe), 8'h00);
    complete_run();
  end
endmodule : tb
